// ==== hw/frsb_regs.svh ====
`ifndef FRSB_REGS_SVH
`define FRSB_REGS_SVH

// command codes
`define FRSB_CMD_CLEAR_FAULTS   8'h03
`define FRSB_CMD_VOV_RESP       8'h41
`define FRSB_CMD_OC_FLT_LIM     8'h46
`define FRSB_CMD_OC_RESP        8'h47
`define FRSB_CMD_OC_WRN_LIM     8'h4A
`define FRSB_CMD_OT_FLT_LIM     8'h4F
`define FRSB_CMD_OT_RESP        8'h50
`define FRSB_CMD_OT_WRN_LIM     8'h51
`define FRSB_CMD_STAT_WORD      8'h79
`define FRSB_CMD_STAT_VOUT      8'h7A
`define FRSB_CMD_STAT_IOUT      8'h7B
`define FRSB_CMD_STAT_INPUT     8'h7C
`define FRSB_CMD_STAT_TEMP      8'h7D
`define FRSB_CMD_STAT_COMM      8'h7E

// response byte fields
`define FRSB_RSP_HI             7
`define FRSB_RSP_LO             6
`define FRSB_RETRY_HI           5
`define FRSB_RETRY_LO           3
`define FRSB_DLY_HI             2
`define FRSB_DLY_LO             0
`define FRSB_RSP_SHUT           2'h2
`define FRSB_RSP_SHUT_OC        2'h3
`define FRSB_RETRY_NONE         3'h0
`define FRSB_RETRY_ALWAYS       3'h7
`define FRSB_DLY_NONE           3'h0

// reset values
`define FRSB_VOV_RESP_RST       8'hB8
`define FRSB_OC_RESP_RST        8'hC0
`define FRSB_OT_RESP_RST        8'hB8
`define FRSB_OC_FLT_RST         16'h0064
`define FRSB_OC_WRN_RST         16'h005A
`define FRSB_OT_FLT_RST         16'h008C
`define FRSB_OT_WRN_RST         16'h007D

// accepted limit ranges, amperes and degrees C
`define FRSB_OC_FLT_MIN         16'h0022
`define FRSB_OC_FLT_MAX         16'h0064
`define FRSB_OC_WRN_MIN         16'h0019
`define FRSB_OC_WRN_MAX         16'h005A
`define FRSB_OT_FLT_MIN         16'h0019
`define FRSB_OT_FLT_MAX         16'h008C
`define FRSB_OT_WRN_MIN         16'h0019
`define FRSB_OT_WRN_MAX         16'h007D

// status bit positions
`define FRSB_SW_VOUT            15
`define FRSB_SW_IOUT            14
`define FRSB_SW_INPUT           13
`define FRSB_SW_OFF             6
`define FRSB_SW_VOV             5
`define FRSB_SW_OC              4
`define FRSB_SW_UV              3
`define FRSB_SW_TEMP            2
`define FRSB_SW_COMM            1
`define FRSB_VOUT_OV            7
`define FRSB_IOUT_OCF           7
`define FRSB_IOUT_OCW           5
`define FRSB_IN_UVF             4
`define FRSB_TEMP_F             7
`define FRSB_TEMP_W             6
`define FRSB_COMM_CMD           7
`define FRSB_COMM_DATA          6
`define FRSB_COMM_PEC           5

// cycles spent off before a normal restart attempt
`define FRSB_RESTART_CYC        16

`endif

// ==== hw/frsb_pkg.sv ====
package frsb_pkg;

    // one decoded host command: code plus optional data word
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] data;
    } frsb_req_s;

    // read answer
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } frsb_rsp_s;

    // live measurements and detector levels
    typedef struct packed {
        logic        ov_det;
        logic        uv_det;
        logic [15:0] iout;
        logic [15:0] temp;
    } frsb_meas_s;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_RUN,
        ST_RETRY,
        ST_LATCH
    } frsb_pwr_e;

endpackage

// ==== hw/frsb_limit_check.sv ====
`timescale 1ns/10ps

// range check plus cross check against the partner limit
module frsb_limit_check #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] i_value,
    input  wire logic [W-1:0] i_min,
    input  wire logic [W-1:0] i_max,
    input  wire logic [W-1:0] i_bound,
    input  wire logic         i_above,
    output logic              o_ok
);

    logic in_range;
    logic cross_ok;

    // bound is strict: equal limits would leave no warning band
    assign in_range = (i_value >= i_min) && (i_value <= i_max);
    assign cross_ok = i_above ? (i_value > i_bound) : (i_value < i_bound);
    assign o_ok     = in_range && cross_ok;

endmodule

// ==== hw/frsb_bank.sv ====
`timescale 1ns/10ps
`include "frsb_regs.svh"

// What this block does
// R01: overvoltage response field accepts only value 10, shutdown then retry policy
// R02: retry field accepts only 000 (no restart) or 111 (keep restarting)
// R03: delay field bits 2..0 accepts only zero
// R04: overvoltage shuts down and latches off until on/off toggle or bias loss
// R05: all default responses shut down with zero delay
// R06: overcurrent fault limit 34..100 A and above the warning limit
// R07: overcurrent response field fixed at 11, shutdown then retry policy
// R08: overcurrent shuts down and latches off until on/off toggle or bias loss
// R09: overcurrent warning limit 25..90 A and below the fault limit
// R10: over-temperature fault limit 25..140 C and above the warning limit
// R11: over-temperature response field accepts only value 10
// R12: over-temperature by default shuts down and keeps restarting while present
// R13: over-temperature warning limit 25..125 C and below the fault limit
// R14: summary word low byte: off, ov, oc, uv, temp, comm bits 6..1
// R15: comm byte flags unsupported command, invalid data, packet check failure
// R16: voltage byte holds its fault flag; current and temperature bytes hold their fault and warning flags
// R17: clear-faults command wipes all flags; each byte also clears per flag
// R18: overvoltage always latches even when its retry field reads 111
module frsb_bank #(
    parameter int LIM_W       = 16,
    parameter int RESTART_CYC = `FRSB_RESTART_CYC
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire frsb_pkg::frsb_req_s  i_req,
    input  wire logic                 i_pec_err,
    input  wire frsb_pkg::frsb_meas_s i_meas,
    input  wire logic                 i_on_ctrl,
    input  wire logic                 i_bias_ok,
    output frsb_pkg::frsb_rsp_s       o_rsp,
    output logic                      o_out_en
);

    localparam int CNT_W = $clog2(RESTART_CYC + 1);

    logic [7:0]       vov_resp_r;
    logic [7:0]       oc_resp_r;
    logic [7:0]       ot_resp_r;
    logic [LIM_W-1:0] oc_flt_r;
    logic [LIM_W-1:0] oc_wrn_r;
    logic [LIM_W-1:0] ot_flt_r;
    logic [LIM_W-1:0] ot_wrn_r;
    logic [7:0]       st_vout_r;
    logic [7:0]       st_iout_r;
    logic [7:0]       st_in_r;
    logic [7:0]       st_temp_r;
    logic [7:0]       st_comm_r;
    logic [15:0]      st_word;
    frsb_pkg::frsb_pwr_e state_r;
    frsb_pkg::frsb_pwr_e state_nxt;
    logic [CNT_W-1:0] cnt_r;
    frsb_pkg::frsb_rsp_s rsp_r;

    logic wr;
    logic rd;
    logic known;
    logic data_ok;
    logic bad_data;
    logic bad_cmd;
    logic clr_all;
    logic ok_ocf;
    logic ok_ocw;
    logic ok_otf;
    logic ok_otw;
    logic resp_ok;
    logic [LIM_W-1:0] wdat;
    logic [2:0] wr_retry;

    // a write flagged with a packet check error is dropped whole
    assign wr   = i_req.valid && i_req.write && !i_pec_err;
    assign rd   = i_req.valid && !i_req.write;
    assign wdat = i_req.data[LIM_W-1:0];
    assign wr_retry = i_req.data[`FRSB_RETRY_HI:`FRSB_RETRY_LO];

    // limit acceptance, each against its partner
    frsb_limit_check #(.W(LIM_W)) u_ocf (
        .i_value (wdat),
        .i_min   (LIM_W'(`FRSB_OC_FLT_MIN)),
        .i_max   (LIM_W'(`FRSB_OC_FLT_MAX)),
        .i_bound (oc_wrn_r),
        .i_above (1'b1),
        .o_ok    (ok_ocf)
    );
    frsb_limit_check #(.W(LIM_W)) u_ocw (
        .i_value (wdat),
        .i_min   (LIM_W'(`FRSB_OC_WRN_MIN)),
        .i_max   (LIM_W'(`FRSB_OC_WRN_MAX)),
        .i_bound (oc_flt_r),
        .i_above (1'b0),
        .o_ok    (ok_ocw)
    );
    frsb_limit_check #(.W(LIM_W)) u_otf (
        .i_value (wdat),
        .i_min   (LIM_W'(`FRSB_OT_FLT_MIN)),
        .i_max   (LIM_W'(`FRSB_OT_FLT_MAX)),
        .i_bound (ot_wrn_r),
        .i_above (1'b1),
        .o_ok    (ok_otf)
    );
    frsb_limit_check #(.W(LIM_W)) u_otw (
        .i_value (wdat),
        .i_min   (LIM_W'(`FRSB_OT_WRN_MIN)),
        .i_max   (LIM_W'(`FRSB_OT_WRN_MAX)),
        .i_bound (ot_flt_r),
        .i_above (1'b0),
        .o_ok    (ok_otw)
    );

    // shared legality of a shutdown-type response byte
    assign resp_ok = (i_req.data[`FRSB_RSP_HI:`FRSB_RSP_LO] == `FRSB_RSP_SHUT) // R01 R11
                  && ((wr_retry == `FRSB_RETRY_NONE)
                      || (wr_retry == `FRSB_RETRY_ALWAYS))                   // R02
                  && (i_req.data[`FRSB_DLY_HI:`FRSB_DLY_LO] == `FRSB_DLY_NONE); // R03

    // command decode: which codes exist and whether write data is legal
    always_comb
    begin
        known   = 1'b1;
        data_ok = 1'b1;
        unique case (i_req.code)
            `FRSB_CMD_CLEAR_FAULTS: data_ok = i_req.write;
            `FRSB_CMD_VOV_RESP:     data_ok = !i_req.write || resp_ok;
            `FRSB_CMD_OC_FLT_LIM:   data_ok = !i_req.write || ok_ocf;
            `FRSB_CMD_OC_RESP:      data_ok = !i_req.write
                                           || (i_req.data[7:0] == `FRSB_OC_RESP_RST); // R07
            `FRSB_CMD_OC_WRN_LIM:   data_ok = !i_req.write || ok_ocw;
            `FRSB_CMD_OT_FLT_LIM:   data_ok = !i_req.write || ok_otf;
            `FRSB_CMD_OT_RESP:      data_ok = !i_req.write || resp_ok;
            `FRSB_CMD_OT_WRN_LIM:   data_ok = !i_req.write || ok_otw;
            `FRSB_CMD_STAT_WORD:    data_ok = !i_req.write;
            `FRSB_CMD_STAT_VOUT,
            `FRSB_CMD_STAT_IOUT,
            `FRSB_CMD_STAT_INPUT,
            `FRSB_CMD_STAT_TEMP,
            `FRSB_CMD_STAT_COMM:    data_ok = 1'b1;
            default:                known   = 1'b0;
        endcase
    end

    assign bad_cmd  = wr && !known || rd && !known;
    assign bad_data = wr && known && !data_ok || rd && known && !data_ok;
    assign clr_all  = wr && (i_req.code == `FRSB_CMD_CLEAR_FAULTS);

    // response bytes: only the overvoltage and temperature retry bits are stored, the rest is fixed
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            vov_resp_r <= `FRSB_VOV_RESP_RST;
            oc_resp_r  <= `FRSB_OC_RESP_RST;
            ot_resp_r  <= `FRSB_OT_RESP_RST;
        end
        else if (wr && data_ok)
        begin
            if (i_req.code == `FRSB_CMD_VOV_RESP)
                vov_resp_r[`FRSB_RETRY_HI:`FRSB_RETRY_LO] <= wr_retry; // R01
            if (i_req.code == `FRSB_CMD_OT_RESP)
                ot_resp_r[`FRSB_RETRY_HI:`FRSB_RETRY_LO] <= wr_retry;  // R11
        end
    end

    // limits: a rejected value leaves the old one in place
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            oc_flt_r <= LIM_W'(`FRSB_OC_FLT_RST);
            oc_wrn_r <= LIM_W'(`FRSB_OC_WRN_RST);
            ot_flt_r <= LIM_W'(`FRSB_OT_FLT_RST);
            ot_wrn_r <= LIM_W'(`FRSB_OT_WRN_RST);
        end
        else if (wr && data_ok)
        begin
            if (i_req.code == `FRSB_CMD_OC_FLT_LIM)
                oc_flt_r <= wdat; // R06
            if (i_req.code == `FRSB_CMD_OC_WRN_LIM)
                oc_wrn_r <= wdat; // R09
            if (i_req.code == `FRSB_CMD_OT_FLT_LIM)
                ot_flt_r <= wdat; // R10
            if (i_req.code == `FRSB_CMD_OT_WRN_LIM)
                ot_wrn_r <= wdat; // R13
        end
    end

    // live detection against the stored limits
    logic oc_flt;
    logic oc_wrn;
    logic ot_flt;
    logic ot_wrn;
    logic latch_flt;
    logic retry_flt;
    logic pwr_ok;

    assign oc_flt = i_meas.iout > oc_flt_r;
    assign oc_wrn = i_meas.iout > oc_wrn_r;
    assign ot_flt = i_meas.temp > ot_flt_r;
    assign ot_wrn = i_meas.temp > ot_wrn_r;
    assign pwr_ok = i_on_ctrl && i_bias_ok;

    // overvoltage latches whatever its retry bits say
    assign latch_flt = i_meas.ov_det                                                  // R04 R18
        || oc_flt && (oc_resp_r[`FRSB_RETRY_HI:`FRSB_RETRY_LO] == `FRSB_RETRY_NONE)   // R08
        || ot_flt && (ot_resp_r[`FRSB_RETRY_HI:`FRSB_RETRY_LO] == `FRSB_RETRY_NONE);  // R02
    assign retry_flt = oc_flt && (oc_resp_r[`FRSB_RETRY_HI:`FRSB_RETRY_LO] == `FRSB_RETRY_ALWAYS)
        || ot_flt && (ot_resp_r[`FRSB_RETRY_HI:`FRSB_RETRY_LO] == `FRSB_RETRY_ALWAYS); // R12

    // power state: no shutdown delay, the fault ends the run at the next edge
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            frsb_pkg::ST_OFF:
                if (pwr_ok)
                    state_nxt = frsb_pkg::ST_RUN;
            frsb_pkg::ST_RUN:
                if (!pwr_ok)
                    state_nxt = frsb_pkg::ST_OFF;
                else if (latch_flt)
                    state_nxt = frsb_pkg::ST_LATCH; // R05
                else if (retry_flt)
                    state_nxt = frsb_pkg::ST_RETRY; // R05
            frsb_pkg::ST_RETRY:
                if (!pwr_ok)
                    state_nxt = frsb_pkg::ST_OFF;
                else if (latch_flt)
                    state_nxt = frsb_pkg::ST_LATCH;
                else if (cnt_r == '0)
                    state_nxt = frsb_pkg::ST_RUN; // R12
            frsb_pkg::ST_LATCH:
                if (!pwr_ok)
                    state_nxt = frsb_pkg::ST_OFF; // R04 R08
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            state_r <= frsb_pkg::ST_OFF;
        else
            state_r <= state_nxt;
    end

    // restart spacing: reloaded every cycle outside the retry wait
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            cnt_r <= CNT_W'(RESTART_CYC - 1);
        else if (state_r != frsb_pkg::ST_RETRY)
            cnt_r <= CNT_W'(RESTART_CYC - 1);
        else if (cnt_r != '0)
            cnt_r <= cnt_r - 1'b1;
    end

    assign o_out_en = (state_r == frsb_pkg::ST_RUN);

    // sticky flag update: a set in the clearing cycle survives
    function automatic logic [7:0] sticky(input logic [7:0] old, input logic [7:0] set,
                                          input logic [7:0] clr);
        sticky = set | (old & ~clr);
    endfunction

    function automatic logic [7:0] clr_mask(input logic [7:0] code, input logic hit_all,
                                            input logic w, input logic [7:0] code_in,
                                            input logic [7:0] wd);
        clr_mask = hit_all ? 8'hFF : ((w && code_in == code) ? wd : 8'h00);
    endfunction

    logic [7:0] set_vout;
    logic [7:0] set_iout;
    logic [7:0] set_in;
    logic [7:0] set_temp;
    logic [7:0] set_comm;

    assign set_vout = {i_meas.ov_det, 7'h00};                          // R16
    assign set_iout = {oc_flt, 1'b0, oc_wrn, 5'h00};                   // R16
    assign set_in   = {3'h0, i_meas.uv_det, 4'h0};
    assign set_temp = {ot_flt, ot_wrn, 6'h00};                         // R16
    assign set_comm = {bad_cmd, bad_data, i_req.valid && i_pec_err, 5'h00}; // R15

    // status bytes, cleared by the clear command or per flag
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st_vout_r <= 8'h00;
            st_iout_r <= 8'h00;
            st_in_r   <= 8'h00;
            st_temp_r <= 8'h00;
            st_comm_r <= 8'h00;
        end
        else
        begin
            st_vout_r <= sticky(st_vout_r, set_vout, clr_mask(`FRSB_CMD_STAT_VOUT, clr_all,
                                wr, i_req.code, i_req.data[7:0])); // R17
            st_iout_r <= sticky(st_iout_r, set_iout, clr_mask(`FRSB_CMD_STAT_IOUT, clr_all,
                                wr, i_req.code, i_req.data[7:0])); // R17
            st_in_r   <= sticky(st_in_r, set_in, clr_mask(`FRSB_CMD_STAT_INPUT, clr_all,
                                wr, i_req.code, i_req.data[7:0])); // R17
            st_temp_r <= sticky(st_temp_r, set_temp, clr_mask(`FRSB_CMD_STAT_TEMP, clr_all,
                                wr, i_req.code, i_req.data[7:0])); // R17
            st_comm_r <= sticky(st_comm_r, set_comm, clr_mask(`FRSB_CMD_STAT_COMM, clr_all,
                                wr, i_req.code, i_req.data[7:0])); // R15
        end
    end

    // summary word assembled from the category bytes, off bit from o_out_en
    always_comb
    begin
        st_word                  = 16'h0000;
        st_word[`FRSB_SW_VOUT]   = |st_vout_r;
        st_word[`FRSB_SW_IOUT]   = |st_iout_r;
        st_word[`FRSB_SW_INPUT]  = |st_in_r;
        st_word[`FRSB_SW_OFF]    = !o_out_en;                 // R14
        st_word[`FRSB_SW_VOV]    = st_vout_r[`FRSB_VOUT_OV];  // R14
        st_word[`FRSB_SW_OC]     = st_iout_r[`FRSB_IOUT_OCF]; // R14
        st_word[`FRSB_SW_UV]     = st_in_r[`FRSB_IN_UVF];     // R14
        st_word[`FRSB_SW_TEMP]   = |st_temp_r;                // R14
        st_word[`FRSB_SW_COMM]   = |st_comm_r;                // R14
    end

    // read answer one cycle after the request, zero for anything refused
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            rsp_r <= '0;
        else
        begin
            rsp_r.valid <= rd;
            unique case (i_req.code)
                `FRSB_CMD_VOV_RESP:    rsp_r.data <= {8'h00, vov_resp_r};
                `FRSB_CMD_OC_FLT_LIM:  rsp_r.data <= 16'(oc_flt_r);
                `FRSB_CMD_OC_RESP:     rsp_r.data <= {8'h00, oc_resp_r};
                `FRSB_CMD_OC_WRN_LIM:  rsp_r.data <= 16'(oc_wrn_r);
                `FRSB_CMD_OT_FLT_LIM:  rsp_r.data <= 16'(ot_flt_r);
                `FRSB_CMD_OT_RESP:     rsp_r.data <= {8'h00, ot_resp_r};
                `FRSB_CMD_OT_WRN_LIM:  rsp_r.data <= 16'(ot_wrn_r);
                `FRSB_CMD_STAT_WORD:   rsp_r.data <= st_word;
                `FRSB_CMD_STAT_VOUT:   rsp_r.data <= {8'h00, st_vout_r};
                `FRSB_CMD_STAT_IOUT:   rsp_r.data <= {8'h00, st_iout_r};
                `FRSB_CMD_STAT_INPUT:  rsp_r.data <= {8'h00, st_in_r};
                `FRSB_CMD_STAT_TEMP:   rsp_r.data <= {8'h00, st_temp_r};
                `FRSB_CMD_STAT_COMM:   rsp_r.data <= {8'h00, st_comm_r};
                default:               rsp_r.data <= 16'h0000;
            endcase
        end
    end

    assign o_rsp = rsp_r;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_vov_fields: assert property (vov_resp_r[7:6] == `FRSB_RSP_SHUT && vov_resp_r[2:0] == 3'h0
        && (vov_resp_r[5:3] == 3'h0 || vov_resp_r[5:3] == 3'h7)) // R01
        else $error("overvoltage response byte holds an illegal field");
    a_resp_retry_legal: assert property (ot_resp_r[5:3] == 3'h0 || ot_resp_r[5:3] == 3'h7) // R02
        else $error("temperature retry field illegal");
    a_resp_delay_zero: assert property (ot_resp_r[2:0] == 3'h0 && ot_resp_r[7:6] == 2'h2) // R03
        else $error("temperature response delay or response field illegal");
    a_ov_latch_hold: assert property (state_r == frsb_pkg::ST_LATCH && pwr_ok
        |=> state_r == frsb_pkg::ST_LATCH && !o_out_en) // R04
        else $error("latched shutdown released while control still on");
    a_ov_shut_now: assert property (o_out_en && pwr_ok && i_meas.ov_det
        |=> !o_out_en ##1 !o_out_en) // R05
        else $error("overvoltage did not stop the output at once");
    a_ocf_range: assert property (!$stable(oc_flt_r) |-> oc_flt_r >= 16'h0022
        && oc_flt_r <= 16'h0064 && oc_flt_r > oc_wrn_r) // R06
        else $error("overcurrent fault limit out of range");
    a_oc_resp_fixed: assert property (oc_resp_r == 8'hC0) // R07
        else $error("overcurrent response byte changed");
    a_oc_latch: assert property (o_out_en && pwr_ok && oc_flt && !i_meas.ov_det
        |=> state_r == frsb_pkg::ST_LATCH) // R08
        else $error("overcurrent did not latch off");
    a_ocw_range: assert property (!$stable(oc_wrn_r) |-> oc_wrn_r >= 16'h0019
        && oc_wrn_r <= 16'h005A && oc_wrn_r < oc_flt_r) // R09
        else $error("overcurrent warning limit out of range");
    a_otf_range: assert property (!$stable(ot_flt_r) |-> ot_flt_r >= 16'h0019
        && ot_flt_r <= 16'h008C && ot_flt_r > ot_wrn_r) // R10
        else $error("temperature fault limit out of range");
    a_ot_retry_path: assert property (o_out_en && pwr_ok && ot_flt && !latch_flt
        && ot_resp_r[5:3] == 3'h7 |=> state_r == frsb_pkg::ST_RETRY [*3]) // R12
        else $error("temperature fault did not enter restart wait");
    a_otw_range: assert property (!$stable(ot_wrn_r) |-> ot_wrn_r >= 16'h0019
        && ot_wrn_r <= 16'h007D && ot_wrn_r < ot_flt_r) // R13
        else $error("temperature warning limit out of range");
    a_word_map: assert property (rd && i_req.code == `FRSB_CMD_STAT_WORD
        |=> o_rsp.valid && o_rsp.data[5] == $past(st_vout_r[7])
        && o_rsp.data[6] == !$past(o_out_en)) // R14
        else $error("summary word bits do not follow the category bytes");
    a_comm_pec: assert property (i_req.valid && i_pec_err |=> st_comm_r[5]) // R15
        else $error("packet check failure not flagged");
    a_temp_flag: assert property (ot_flt |=> st_temp_r[7]) // R16
        else $error("temperature fault flag not set");
    a_clear_all: assert property (clr_all && !i_meas.ov_det |=> st_vout_r == 8'h00) // R17
        else $error("clear command left a voltage flag standing");
    a_ov_ignores_retry: assert property (o_out_en && pwr_ok && i_meas.ov_det
        && vov_resp_r[5:3] == 3'h7 |=> state_r == frsb_pkg::ST_LATCH) // R18
        else $error("overvoltage took the restart path");

endmodule

// ==== tb/frsb_host.sv ====
`timescale 1ns/10ps

// host model: one command per call, answer taken a cycle later
module frsb_host (
    input  wire logic                i_clk,
    input  wire frsb_pkg::frsb_rsp_s i_rsp,
    output frsb_pkg::frsb_req_s      o_req,
    output logic                     o_pec
);
    logic [15:0] rd_data;

    // bus idle until asked
    initial
    begin
        o_req = '0;
        o_pec = 1'b0;
    end

    // no answer reads as unknown, so a silent read never matches
    task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d, input logic p);
        @(negedge i_clk);
        o_req = {1'b1, w, c, d};
        o_pec = p;
        @(negedge i_clk);
        o_req = '0;
        o_pec = 1'b0;
        rd_data = i_rsp.valid === 1'b1 ? i_rsp.data : 16'hXXXX;
    endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps

module tb_top;
    localparam int        RC = 4;
    logic                 i_clk;
    logic                 i_rst;
    logic                 pec;
    logic                 on;
    logic                 bias;
    logic                 oen;
    frsb_pkg::frsb_req_s  req;
    frsb_pkg::frsb_rsp_s  rsp;
    frsb_pkg::frsb_meas_s meas;
    int                   err_count;
    int                   cmp_count;
    logic [15:0]          lm[4] = '{16'h0064, 16'h005A, 16'h008C, 16'h007D};
    logic [15:0]          hi[4] = '{16'h0064, 16'h005A, 16'h008C, 16'h007D};
    logic [15:0]          lo[4] = '{16'h0022, 16'h0019, 16'h0019, 16'h0019};
    logic [7:0]           lc[4] = '{8'h46, 8'h4A, 8'h4F, 8'h51};
    logic [7:0]           rc[3] = '{8'h41, 8'h47, 8'h50};
    logic [7:0]           rv[3] = '{8'hB8, 8'hC0, 8'hB8};

    frsb_bank #(.RESTART_CYC(RC)) DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_pec_err(pec), .i_meas(meas),
        .i_on_ctrl(on), .i_bias_ok(bias), .o_rsp(rsp), .o_out_en(oen));
    frsb_host host (.i_clk(i_clk), .i_rsp(rsp), .o_req(req), .o_pec(pec));

    // 125 MHz
    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // even index limits sit above their partner, odd below
    function automatic logic lim_ok(int k, logic [15:0] v);
        return v >= lo[k] && v <= hi[k] && (k[0] ? v < lm[k ^ 1] : v > lm[k ^ 1]);
    endfunction

    function automatic logic rsp_ok(logic [7:0] c, logic [7:0] d);
        if (c == 8'h47)
            return d == 8'hC0;
        return d[7:6] == 2'h2 && (d[5:3] == 3'h0 || d[5:3] == 3'h7) && d[2:0] == 3'h0;
    endfunction

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        host.cmd(1'b0, c, 16'h0000, 1'b0);
        chk(host.rd_data, e);
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        host.cmd(1'b1, c, d, 1'b0);
    endtask

    // read the comm byte, then wipe it per flag
    task automatic comm(input logic [7:0] e);
        rd(8'h7E, {8'h00, e});
        wr(8'h7E, 16'h00FF);
    endtask

    task automatic cycle_on();
        on = 1'b0;
        @(negedge i_clk);
        on = 1'b1;
        repeat (3) @(negedge i_clk);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // main sequence
    initial
    begin
        int          k;
        int          n;
        logic [15:0] v;
        logic [7:0]  d;
        logic [7:0]  c;
        logic [31:0] r;
        err_count = 0;
        cmp_count = 0;
        i_rst = 1'b1;
        meas = '0;
        on = 1'b0;
        bias = 1'b1;
        k = $urandom(32'h2A21);
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        for (k = 0; k < 3; k++)
            rd(rc[k], {8'h00, rv[k]});
        $display("reset test done");
        // first eight draws hit the range edges
        for (n = 0; n < 32; n++)
        begin
            k = $urandom_range(3);
            v = n < 8 ? (n[0] ? lo[k] - n[1] : hi[k] + n[1]) : 16'($urandom_range(141, 24));
            d = lim_ok(k, v) ? 8'h00 : 8'h40;
            wr(lc[k], v);
            if (d == 8'h00)
                lm[k] = v;
            rd(lc[k], lm[k]);
            comm(d);
        end
        $display("limit test done");
        for (n = 0; n < 24; n++)
        begin
            k = n % 3;
            r = $urandom;
            d = {r[8] ? 2'h2 : r[7:6], r[5] ? {3{r[4]}} : r[3:1], r[0] ? 3'h0 : r[11:9]};
            if (n < 3)
                d = k == 1 ? 8'hC0 : 8'h80;
            c = rsp_ok(rc[k], d) ? 8'h00 : 8'h40;
            wr(rc[k], {8'h00, d});
            if (c == 8'h00)
                rv[k] = d;
            rd(rc[k], {8'h00, rv[k]});
            comm(c);
        end
        wr(8'h50, 16'h00B8);
        wr(8'h41, 16'h00B8);
        $display("response test done");
        host.cmd(1'b0, 8'h99, 16'h0000, 1'b0);
        chk(host.rd_data, 16'h0000);
        host.cmd(1'b1, 8'h46, 16'h0030, 1'b1);
        rd(8'h46, lm[0]);
        rd(8'h79, 16'h0042);
        rd(8'h7E, 16'h00A0);
        wr(8'h03, 16'h0000);
        rd(8'h7E, 16'h0000);
        $display("comm test done");
        cycle_on();
        chk(16'(oen), 16'h0001);
        meas.ov_det = 1'b1;
        @(negedge i_clk);
        chk(16'(oen), 16'h0000);
        meas.ov_det = 1'b0;
        repeat (8) @(negedge i_clk);
        chk(16'(oen), 16'h0000);
        rd(8'h79, 16'h8060);
        rd(8'h7A, 16'h0080);
        wr(8'h03, 16'h0000);
        cycle_on();
        chk(16'(oen), 16'h0001);
        meas.iout = lm[0] + 16'h0001;
        @(negedge i_clk);
        chk(16'(oen), 16'h0000);
        meas.iout = 16'h0000;
        repeat (8) @(negedge i_clk);
        chk(16'(oen), 16'h0000);
        rd(8'h7B, 16'h00A0);
        wr(8'h03, 16'h0000);
        cycle_on();
        $display("latch test done");
        meas.temp = lm[2] + 16'h0001;
        @(negedge i_clk);
        meas.temp = 16'h0000;
        n = 0;
        while (oen === 1'b0 && n < 50)
        begin
            n++;
            @(negedge i_clk);
        end
        chk(16'(n), 16'(RC));
        if (n == 50)
            wrap_up();
        rd(8'h7D, 16'h00C0);
        wr(8'h7D, 16'h0080);
        rd(8'h7D, 16'h0040);
        bias = 1'b0;
        @(negedge i_clk);
        chk(16'(oen), 16'h0000);
        meas.uv_det = 1'b1;
        @(negedge i_clk);
        meas.uv_det = 1'b0;
        rd(8'h7C, 16'h0010);
        rd(8'h79, 16'h204C);
        $display("restart test done");
        wrap_up();
    end
endmodule
